// *** inc/rxhdr_pkg.sv ***
/*
 * Shared constants for the receive buffer header registers: register
 * offsets, field positions, reset values and enumerations.
 * Assumes byte-wide registers on a plain strobe port with an 8-bit address.
 */
package rxhdr_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   localparam logic [7:0] OFS_IDENT_HIGH   = 8'h00;
   localparam logic [7:0] OFS_IDENT_LOW    = 8'h01;
   localparam logic [7:0] OFS_EXT_HIGH     = 8'h02;
   localparam logic [7:0] OFS_EXT_LOW      = 8'h03;
   localparam logic [7:0] OFS_LENGTH_CTRL  = 8'h04;
   localparam logic [7:0] OFS_BUF_CTRL     = 8'h05;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h06;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h07;

   // Identifier low byte field positions.
   localparam int unsigned POS_SRR         = 4;
   localparam int unsigned POS_EXT_FLAG    = 3;
   localparam int unsigned POS_TOP_PAIR    = 0;
   // Length/control field positions.
   localparam int unsigned POS_REMOTE      = 6;
   localparam int unsigned POS_RB1         = 5;
   localparam int unsigned POS_RB0         = 4;
   // Buffer control field position.
   localparam int unsigned POS_FULL        = 7;
   // Interrupt status bit positions.
   localparam int unsigned IRQ_LOADED      = 0;
   localparam int unsigned IRQ_OVERRUN     = 1;
   localparam int unsigned IRQ_BAD_LENGTH  = 2;
   localparam int unsigned IRQ_BITS        = 3;

   localparam logic [3:0] DLC_MAX          = 4'h8;
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam logic [2:0] IRQ_RESET        = 3'h0;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // Header words held in the small register memory.
   typedef enum logic [1:0] {
      HDR_IDENT_HIGH = 2'b00,
      HDR_IDENT_LOW  = 2'b01,
      HDR_EXT_HIGH   = 2'b10,
      HDR_EXT_LOW    = 2'b11
   } hdr_word_t;

   typedef enum logic [0:0] {
      BUF_OPEN = 1'b0,
      BUF_FULL = 1'b1
   } buf_state_t;

endpackage

// *** inc/hdr_mem_if.sv ***
/*
 * Carrier between the header register file and its small memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface hdr_mem_if;
   logic                    wr_en;
   rxhdr_pkg::hdr_word_t    wr_addr;
   logic [7:0]              wr_data;
   rxhdr_pkg::hdr_word_t    rd_addr;
   logic [7:0]              rd_data;

   modport owner (
      output wr_en,
      output wr_addr,
      output wr_data,
      output rd_addr,
      input  rd_data
   );
   modport store (
      input  wr_en,
      input  wr_addr,
      input  wr_data,
      input  rd_addr,
      output rd_data
   );
endinterface

// *** hdl/hdr_word_mem.sv ***
/*
 * Four-word by eight-bit memory holding the captured identifier bytes.
 * Read data come from a register one cycle after the address. Contents
 * are not reset, matching the undefined power-on state of the header.
 */
`timescale 1ns/1ps
module hdr_word_mem (
   input  wire logic ref_clk,
   hdr_mem_if.store  mem
);

   logic [7:0] words_q [4];
   logic [7:0] rd_q;

   always_ff @(posedge ref_clk) begin
      if (mem.wr_en) begin
         words_q[mem.wr_addr] <= mem.wr_data;
      end
      rd_q <= words_q[mem.rd_addr];
   end

   assign mem.rd_data = rd_q;

endmodule

// *** hdl/can_rx_buffer_id_length_regs.sv ***
/*
 * Register view of one CAN receive buffer's captured frame header, with
 * buffer-full flag, event status, mask and a level interrupt.
 * Assumes the protocol engine presents a whole decoded header beside a
 * one-cycle load pulse on ref_clk, and a software master that issues
 * one-cycle read or write strobes and takes read data one cycle later.
 */
`timescale 1ns/1ps

// Functional notes
// - High ident byte: standard bits 10..3, or extended bits 28..21.
// - Low ident bits 7..5: standard bits 2..0, or extended bits 20..18.
// - Low ident bit 4 captures SRR, only for extended frames.
// - Extended high byte holds extended identifier bits 15..8.
// - Extended low byte holds bits 7..0; low ident bits 1..0 hold 17..16.
// - Reserved control bits at length bits 5 and 4 read as zero.
// - Loading a frame sets buffer-full; software clears it after reading.
module can_rx_buffer_id_length_regs (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        frame_load,
   input  wire logic        frame_extended,
   input  wire logic [28:0] frame_ident,
   input  wire logic        frame_srr,
   input  wire logic        frame_remote,
   input  wire logic [3:0]  frame_dlc,
   output logic             buffer_full_flag,
   output logic             irq
);

   hdr_mem_if mem ();

   hdr_word_mem u_mem (
      .ref_clk (ref_clk),
      .mem     (mem)
   );

   // Captured header bytes formed from the incoming frame.
   logic [7:0] cap_ident_high;
   logic [7:0] cap_ident_low;
   logic [7:0] cap_ext_high;
   logic [7:0] cap_ext_low;

   // Extended frames place ident bits 28..18 where standard bits 10..0 sit.
   assign cap_ident_high = frame_extended ? frame_ident[28:21]
                                          : frame_ident[10:3];
   assign cap_ident_low  = {frame_extended ? frame_ident[20:18]
                                           : frame_ident[2:0],
                            frame_extended & frame_srr,
                            frame_extended,
                            1'b0,
                            frame_extended ? frame_ident[17:16] : 2'b00};
   assign cap_ext_high   = frame_extended ? frame_ident[15:8] : 8'h00;
   assign cap_ext_low    = frame_extended ? frame_ident[7:0] : 8'h00;

   // Decode of the software port.
   logic hit_ident_high;
   logic hit_ident_low;
   logic hit_ext_high;
   logic hit_ext_low;
   logic hit_length;
   logic hit_buf_ctrl;
   logic hit_status;
   logic hit_mask;
   logic hit_hdr;

   assign hit_ident_high = (reg_addr == rxhdr_pkg::OFS_IDENT_HIGH);
   assign hit_ident_low  = (reg_addr == rxhdr_pkg::OFS_IDENT_LOW);
   assign hit_ext_high   = (reg_addr == rxhdr_pkg::OFS_EXT_HIGH);
   assign hit_ext_low    = (reg_addr == rxhdr_pkg::OFS_EXT_LOW);
   assign hit_length     = (reg_addr == rxhdr_pkg::OFS_LENGTH_CTRL);
   assign hit_buf_ctrl   = (reg_addr == rxhdr_pkg::OFS_BUF_CTRL);
   assign hit_status     = (reg_addr == rxhdr_pkg::OFS_IRQ_STATUS);
   assign hit_mask       = (reg_addr == rxhdr_pkg::OFS_IRQ_MASK);
   assign hit_hdr        = hit_ident_high | hit_ident_low | hit_ext_high | hit_ext_low;

   // Software may overwrite a header byte, but a frame load in the same
   // cycle wins so that a captured frame is never half overwritten.
   logic               sw_hdr_wr;
   rxhdr_pkg::hdr_word_t sw_word;

   assign sw_hdr_wr = reg_wr & hit_hdr & ~frame_load;
   assign sw_word   = rxhdr_pkg::hdr_word_t'(reg_addr[1:0]);

   // Bit 2 of the ident low byte is not implemented, so software cannot set it.
   logic [7:0] sw_wdata;
   assign sw_wdata = hit_ident_low ? (reg_wdata & 8'hfb) : reg_wdata;

   // The memory is written one word per cycle, so a load is spread over
   // four cycles from a small staging copy of the captured bytes.
   logic [7:0] stage_q [4];
   logic [2:0] stage_cnt_q;
   logic       staging;

   assign staging = (stage_cnt_q != 3'h0);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_cnt_q <= 3'h0;
      end else if (frame_load) begin
         stage_cnt_q <= 3'h4;
      end else if (staging) begin
         stage_cnt_q <= stage_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (frame_load) begin
         stage_q[0] <= cap_ident_high;
         stage_q[1] <= cap_ident_low;
         stage_q[2] <= cap_ext_high;
         stage_q[3] <= cap_ext_low;
      end
   end

   // Word index being staged counts 0..3 as stage_cnt_q runs 4..1.
   logic [1:0] stage_word;
   assign stage_word = 2'(3'h4 - stage_cnt_q);

   assign mem.wr_en   = staging | sw_hdr_wr;
   assign mem.wr_addr = staging ? rxhdr_pkg::hdr_word_t'(stage_word) : sw_word;
   assign mem.wr_data = staging ? stage_q[stage_word] : sw_wdata;
   assign mem.rd_addr = sw_word;

   // Shadow of the header for reads during staging, so a read right after
   // the load already returns the new frame.
   logic       shadow_sel;
   logic [7:0] shadow_byte;
   assign shadow_sel  = staging;
   assign shadow_byte = stage_q[sw_word];

   // Length and control register.
   logic       remote_q;
   logic [3:0] dlc_q;
   logic       full_q;
   logic [2:0] status_q;
   logic [2:0] mask_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         remote_q <= 1'b0;
         dlc_q    <= 4'h0;
      end else if (frame_load) begin
         remote_q <= frame_remote;
         dlc_q    <= frame_dlc;
      end else if (reg_wr && hit_length) begin
         remote_q <= reg_wdata[rxhdr_pkg::POS_REMOTE];
         dlc_q    <= reg_wdata[3:0];
      end
   end

   // Buffer full: set by a load, cleared by software writing zero to it.
   logic full_d;
   assign full_d = frame_load ? 1'b1
                 : (reg_wr && hit_buf_ctrl && !reg_wdata[rxhdr_pkg::POS_FULL]) ? 1'b0
                 : full_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         full_q <= 1'b0;
      end else begin
         full_q <= full_d;
      end
   end

   // Event status: sets win over write-one-to-clear in the same cycle.
   logic [2:0] events;
   logic [2:0] status_d;
   logic [2:0] status_clr;

   assign events[rxhdr_pkg::IRQ_LOADED]     = frame_load;
   assign events[rxhdr_pkg::IRQ_OVERRUN]    = frame_load & full_q;
   assign events[rxhdr_pkg::IRQ_BAD_LENGTH] = frame_load & (frame_dlc > rxhdr_pkg::DLC_MAX);
   assign status_clr = (reg_wr && hit_status) ? reg_wdata[2:0] : 3'h0;
   assign status_d   = (status_q & ~status_clr) | events;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q <= rxhdr_pkg::IRQ_RESET;
         mask_q   <= rxhdr_pkg::IRQ_RESET;
      end else begin
         status_q <= status_d;
         if (reg_wr && hit_mask) begin
            mask_q <= reg_wdata[2:0];
         end
      end
   end

   // Read path: header words come from the memory or its staging shadow,
   // the rest from flip-flops, all landing in the cycle after the strobe.
   logic       rd_hdr_q;
   logic       rd_shadow_q;
   logic [7:0] shadow_q;
   logic [7:0] local_q;
   logic [7:0] local_d;
   logic [7:0] length_view;

   assign length_view = {1'b0, remote_q, 2'b00, dlc_q};

   assign local_d = !reg_rd      ? 8'h00
                  : hit_length   ? length_view
                  : hit_buf_ctrl ? {full_q, 7'h00}
                  : hit_status   ? {5'h00, status_q}
                  : hit_mask     ? {5'h00, mask_q}
                  : rxhdr_pkg::READ_UNMAPPED;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_hdr_q    <= 1'b0;
         rd_shadow_q <= 1'b0;
         shadow_q    <= rxhdr_pkg::REG_RESET;
         local_q     <= rxhdr_pkg::REG_RESET;
      end else begin
         rd_hdr_q    <= reg_rd & hit_hdr;
         rd_shadow_q <= reg_rd & hit_hdr & shadow_sel;
         shadow_q    <= shadow_byte;
         local_q     <= local_d;
      end
   end

   // A read in the load cycle itself still returns the previous frame's byte,
   // since the new header is only captured at that edge.
   logic [7:0] rdata_mux;
   assign rdata_mux = !rd_hdr_q   ? local_q
                    : rd_shadow_q ? shadow_q
                    : mem.rd_data;

   always_comb begin
      reg_rdata = rdata_mux;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         buffer_full_flag <= 1'b0;
         irq              <= 1'b0;
      end else begin
         buffer_full_flag <= full_d;
         irq              <= |(status_d & mask_q);
      end
   end

   property p_full_set;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load |=> full_q ##0 buffer_full_flag;
   endproperty
   a_full_set: assert property (p_full_set) else $error("load did not set full");

   property p_full_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      full_q && !(reg_wr && hit_buf_ctrl) |=> full_q;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full dropped alone");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      reg_rd && hit_length |=> reg_rdata[5:4] == 2'b00 && reg_rdata[7] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_dlc_read;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load ##1 (reg_rd && hit_length && !frame_load && !reg_wr)
         |=> reg_rdata[3:0] == $past(frame_dlc, 2);
   endproperty
   a_dlc_read: assert property (p_dlc_read) else $error("length wrong");

   property p_high_cap;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load |=> stage_q[0] == ($past(frame_extended) ? $past(frame_ident[28:21])
                                                           : $past(frame_ident[10:3]));
   endproperty
   a_high_cap: assert property (p_high_cap) else $error("high ident wrong");

   property p_low_cap;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load |=> stage_q[1][7:5] == ($past(frame_extended) ? $past(frame_ident[20:18])
                                                                : $past(frame_ident[2:0]));
   endproperty
   a_low_cap: assert property (p_low_cap) else $error("low ident wrong");

   property p_srr_cap;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load |=> stage_q[1][4] == ($past(frame_extended) && $past(frame_srr))
                     && stage_q[1][2] == 1'b0;
   endproperty
   a_srr_cap: assert property (p_srr_cap) else $error("srr wrong");

   property p_ext_cap;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load && frame_extended |=> stage_q[2] == $past(frame_ident[15:8])
                     && stage_q[3] == $past(frame_ident[7:0]);
   endproperty
   a_ext_cap: assert property (p_ext_cap) else $error("ext ident wrong");

   property p_pair_cap;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load && frame_extended |=> stage_q[1][1:0] == $past(frame_ident[17:16]);
   endproperty
   a_pair_cap: assert property (p_pair_cap) else $error("top pair wrong");

   property p_irq_level;
      @(posedge ref_clk) disable iff (!rst_b)
      irq == |($past(status_d) & $past(mask_q));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

   property p_low_bit2_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      mem.wr_en && mem.wr_addr == rxhdr_pkg::HDR_IDENT_LOW |-> mem.wr_data[2] == 1'b0;
   endproperty
   a_low_bit2_zero: assert property (p_low_bit2_zero) else $error("ident low bit 2 set");

   property p_std_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load && !frame_extended |=> stage_q[2] == 8'h00 && stage_q[3] == 8'h00
                     && stage_q[1][4:0] == 5'h00;
   endproperty
   a_std_zero: assert property (p_std_zero) else $error("standard frame extras set");

   property p_load_read;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_load ##2 (reg_rd && hit_ident_high && !frame_load)
         |=> reg_rdata == ($past(frame_extended, 3) ? $past(frame_ident[28:21], 3)
                                                    : $past(frame_ident[10:3], 3));
   endproperty
   a_load_read: assert property (p_load_read) else $error("staged read wrong");

   property p_full_clear;
      @(posedge ref_clk) disable iff (!rst_b)
      reg_wr && hit_buf_ctrl && !reg_wdata[rxhdr_pkg::POS_FULL] && !frame_load |=> !full_q;
   endproperty
   a_full_clear: assert property (p_full_clear) else $error("full not cleared");

   c_ext_load: cover property (@(posedge ref_clk) disable iff (!rst_b)
      frame_load && frame_extended);
   c_overrun: cover property (@(posedge ref_clk) disable iff (!rst_b)
      frame_load && full_q);
   c_clear_full: cover property (@(posedge ref_clk) disable iff (!rst_b)
      full_q ##1 !full_q);
   c_stage_read: cover property (@(posedge ref_clk) disable iff (!rst_b)
      reg_rd && hit_hdr && staging);

endmodule

// *** sim/frame_engine_model.sv ***
/*
 * Behavioural stand-in for the protocol engine that hands decoded frame
 * headers to the receive buffer header registers.
 * Assumes the bench calls send_frame from one process at a time.
 */
`timescale 1ns/1ps
module frame_engine_model (
   input  wire logic        ref_clk,
   output logic             frame_load,
   output logic             frame_extended,
   output logic [28:0]      frame_ident,
   output logic             frame_srr,
   output logic             frame_remote,
   output logic [3:0]       frame_dlc
);
   time last_load = 0;

   initial begin
      frame_load     = 1'b0;
      frame_extended = 1'b0;
      frame_ident    = 29'h0;
      frame_srr      = 1'b0;
      frame_remote   = 1'b0;
      frame_dlc      = 4'h0;
   end

   // Returns at the edge that samples the load pulse.
   task automatic send_frame(input logic x, input logic [28:0] id, input logic s,
                             input logic r, input logic [3:0] d);
      @(posedge ref_clk);
      while ($time - last_load < 50) @(posedge ref_clk);
      frame_load     <= 1'b1;
      frame_extended <= x;
      frame_ident    <= id;
      frame_srr      <= s;
      frame_remote   <= r;
      frame_dlc      <= d;
      last_load = $time;
      @(posedge ref_clk);
      // Header lines are only valid with the pulse, so they go stale here.
      frame_load     <= 1'b0;
      frame_extended <= ~x;
      frame_ident    <= ~id;
      frame_srr      <= ~s;
      frame_remote   <= ~r;
      frame_dlc      <= ~d;
   endtask
endmodule

// *** sim/can_rx_buffer_id_length_regs_tb.sv ***
/*
 * Self-checking bench for the receive buffer header registers.
 * Assumes the design package is compiled first and the engine model beside it.
 */
`timescale 1ns/1ps
module can_rx_buffer_id_length_regs_tb;
   logic        ref_clk, rst_b, reg_wr, reg_rd, buffer_full_flag, irq;
   logic        frame_load, frame_extended, frame_srr, frame_remote;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v;
   logic [28:0] frame_ident, id;
   logic [3:0]  frame_dlc, dlc;
   logic        ext, srr, rem;
   logic [7:0]  ofs [5];
   int          err_count = 0;
   int          num_checks = 0;
   int          seed = 72;

   can_rx_buffer_id_length_regs u_can_rx_buffer_id_length_regs (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_load(frame_load),
      .frame_extended(frame_extended), .frame_ident(frame_ident), .frame_srr(frame_srr),
      .frame_remote(frame_remote), .frame_dlc(frame_dlc),
      .buffer_full_flag(buffer_full_flag), .irq(irq));

   frame_engine_model u_frame_engine_model (
      .ref_clk(ref_clk), .frame_load(frame_load), .frame_extended(frame_extended),
      .frame_ident(frame_ident), .frame_srr(frame_srr), .frame_remote(frame_remote),
      .frame_dlc(frame_dlc));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      summarize();
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value t=%0t %s got %h exp %h", $time, what, got, exp);
         err_count++;
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
      logic [7:0] v;
      rd_reg(a, v);
      chk(v, e, what);
   endtask

   function automatic logic [7:0] exp_hdr(input int k, input logic x, input logic [28:0] i,
                                          input logic s, input logic r, input logic [3:0] d);
      case (k)
         0: return x ? i[28:21] : i[10:3];
         1: return x ? {i[20:18], s, 1'b1, 1'b0, i[17:16]} : {i[2:0], 5'h00};
         2: return x ? i[15:8] : 8'h00;
         3: return x ? i[7:0] : 8'h00;
         default: return {1'b0, r, 2'b00, d};
      endcase
   endfunction

   initial begin
      ofs = '{rxhdr_pkg::OFS_IDENT_HIGH, rxhdr_pkg::OFS_IDENT_LOW, rxhdr_pkg::OFS_EXT_HIGH,
              rxhdr_pkg::OFS_EXT_LOW, rxhdr_pkg::OFS_LENGTH_CTRL};
      rst_b     = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      chk({7'h00, buffer_full_flag}, 8'h00, "full at reset");
      rd_chk(rxhdr_pkg::OFS_LENGTH_CTRL, 8'h00, "length reset");
      rd_chk(rxhdr_pkg::OFS_BUF_CTRL, 8'h00, "ctrl reset");
      rd_chk(rxhdr_pkg::OFS_IRQ_STATUS, 8'h00, "status reset");
      rd_chk(rxhdr_pkg::OFS_IRQ_MASK, 8'h00, "mask reset");
      for (int i = 0; i < 3; i++) rd_chk(8'h08 | 8'($random(seed)), 8'h00, "unmapped");
      // Every length code, both frame formats, back to back with clears.
      for (int i = 0; i < 16; i++) begin
         ext = i[0];
         id  = 29'($random(seed));
         srr = 1'($random(seed));
         rem = 1'($random(seed));
         dlc = 4'(i);
         wr_reg(rxhdr_pkg::OFS_BUF_CTRL, 8'h00);
         wr_reg(rxhdr_pkg::OFS_IRQ_STATUS, 8'h07);
         u_frame_engine_model.send_frame(ext, id, srr, rem, dlc);
         @(posedge ref_clk);
         #1 chk({7'h00, buffer_full_flag}, 8'h01, "full after load");
         repeat (4) @(posedge ref_clk);
         for (int k = 0; k < 5; k++) rd_chk(ofs[k], exp_hdr(k, ext, id, srr, rem, dlc), "hdr");
         rd_chk(rxhdr_pkg::OFS_IRQ_STATUS, {5'h00, dlc > 4'h8, 2'b01}, "status");
      end
      // Load while still full flags an overrun and keeps the flag up.
      u_frame_engine_model.send_frame(1'b1, 29'h1abcdef3, 1'b1, 1'b0, 4'h3);
      repeat (6) @(posedge ref_clk);
      rd_chk(rxhdr_pkg::OFS_IRQ_STATUS, 8'h07, "overrun");
      chk({7'h00, irq}, 8'h00, "irq masked off");
      wr_reg(rxhdr_pkg::OFS_IRQ_MASK, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1 chk({7'h00, irq}, 8'h01, "irq on");
      wr_reg(rxhdr_pkg::OFS_IRQ_STATUS, 8'h05);
      rd_chk(rxhdr_pkg::OFS_IRQ_STATUS, 8'h02, "partial clear");
      chk({7'h00, irq}, 8'h01, "irq held");
      wr_reg(rxhdr_pkg::OFS_IRQ_STATUS, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1 chk({7'h00, irq}, 8'h00, "irq off");
      wr_reg(rxhdr_pkg::OFS_BUF_CTRL, 8'h80);
      rd_chk(rxhdr_pkg::OFS_BUF_CTRL, 8'h80, "full kept");
      wr_reg(rxhdr_pkg::OFS_BUF_CTRL, 8'h00);
      rd_chk(rxhdr_pkg::OFS_BUF_CTRL, 8'h00, "full cleared");
      chk({7'h00, buffer_full_flag}, 8'h00, "flag cleared");
      // Software writes to the header bytes.
      wr_reg(rxhdr_pkg::OFS_IDENT_HIGH, 8'ha5);
      rd_chk(rxhdr_pkg::OFS_IDENT_HIGH, 8'ha5, "ident high rw");
      wr_reg(rxhdr_pkg::OFS_IDENT_LOW, 8'hff);
      rd_chk(rxhdr_pkg::OFS_IDENT_LOW, 8'hfb, "ident low rw");
      wr_reg(rxhdr_pkg::OFS_EXT_HIGH, 8'h5a);
      rd_chk(rxhdr_pkg::OFS_EXT_HIGH, 8'h5a, "ext high rw");
      wr_reg(rxhdr_pkg::OFS_EXT_LOW, 8'h3c);
      rd_chk(rxhdr_pkg::OFS_EXT_LOW, 8'h3c, "ext low rw");
      wr_reg(rxhdr_pkg::OFS_LENGTH_CTRL, 8'hff);
      rd_reg(rxhdr_pkg::OFS_LENGTH_CTRL, rd_v);
      chk(rd_v, 8'h4f, "length zero bits");
      // Header bytes read back while the load is still being staged, then ident low once staging is done.
      u_frame_engine_model.send_frame(1'b0, 29'h00000005, 1'b1, 1'b1, 4'h2);
      reg_rd   <= 1'b1;
      reg_addr <= rxhdr_pkg::OFS_LENGTH_CTRL;
      @(posedge ref_clk);
      reg_addr <= rxhdr_pkg::OFS_IDENT_HIGH;
      #1 chk(reg_rdata, 8'h42, "length at load");
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 8'h00, "ident high staging");
      rd_chk(rxhdr_pkg::OFS_EXT_LOW, 8'h00, "ext low staging");
      rd_chk(rxhdr_pkg::OFS_IDENT_LOW, 8'ha0, "ident low after");
      summarize();
   end
endmodule
